// ---- logic/backlight_pkg.sv ----
// Constants, register map and state codes for the backlight sink and timeout block
// Function
// - Select bit 1 independent, 0 follows group enable
// - LED n select sits at bit n-1
// - Off delay 7 bits, N seconds, zero disables
// - Off delay expiry switches backlight group off
// - Off delay follows dim delay when dimming enabled
// - Dim delay 7 bits, N seconds, zero disables
// - Dim expiry moves target from maximum to dim
// - Dim count starts once maximum current reached
// - Timeout transitions use fade-out rate, 0000 instant
package backlight_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SECOND_NS = 1000000000;
    localparam int unsigned TICK_CYCLES_DEFAULT = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_W = 27;

    localparam int unsigned LED_COUNT = 7;
    localparam int unsigned DELAY_W = 7;
    localparam int unsigned REG_W = 8;
    localparam int unsigned FADE_W = 4;

    localparam logic [7:0] ADDR_SINK_ASSIGN = 8'h05;
    localparam logic [7:0] ADDR_OFF_DELAY = 8'h06;
    localparam logic [7:0] ADDR_DIM_DELAY = 8'h07;

    localparam logic [6:0] SINK_ASSIGN_RESET = 7'h00;
    localparam logic [6:0] OFF_DELAY_RESET = 7'h00;
    localparam logic [6:0] DIM_DELAY_RESET = 7'h00;
    localparam logic [6:0] DELAY_DISABLED = 7'h00;
    localparam logic [3:0] FADE_INSTANT = 4'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    typedef enum logic [5:0] {
        ST_IDLE      = 6'b000001,
        ST_RAMP      = 6'b000010,
        ST_COUNT_DIM = 6'b000100,
        ST_COUNT_OFF = 6'b001000,
        ST_HOLD      = 6'b010000,
        ST_TIMED_OFF = 6'b100000
    } timeout_state_type;
endpackage

// ---- logic/backlight_sink_and_timeouts.sv ----
// Sink group assignment registers and cascaded dim and off timeouts
`timescale 1ns/1ps
module backlight_sink_and_timeouts
    import backlight_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
    input wire logic clk, // System clock, 100 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Register write data
    input wire logic reg_write, // Write strobe, one cycle
    input wire logic reg_read, // Read strobe, one cycle
    output logic [7:0] reg_rdata_q, // Read data, valid cycle after strobe
    input wire logic backlight_group_enable, // Shared backlight group enable
    input wire logic at_max_current, // Backlight has reached maximum current
    input wire logic [FADE_W-1:0] fade_out_rate, // Programmed fade-out rate code
    input wire logic [LED_COUNT-1:0] led_independent_on, // Per-LED independent enables
    output logic [LED_COUNT-1:0] sink_on_q, // Per-LED sink enable
    output logic target_dim_q, // Group target is dim current
    output logic group_off_q, // Group switched off by timeout
    output logic [FADE_W-1:0] transition_rate_q, // Rate for current timeout change
    output logic transition_instant_q, // Timeout change is immediate
    output logic transition_pulse_q // One cycle at each timeout change
);
    logic [LED_COUNT-1:0] sink_assign_q;
    logic [DELAY_W-1:0] off_delay_q;
    logic [DELAY_W-1:0] dim_delay_q;
    logic [TICK_W-1:0] prescale_q;
    logic tick;
    logic enable_prev_q;
    logic arm;
    logic dim_done;
    logic off_done;
    logic dim_enabled;
    logic off_enabled;
    logic dim_expire;
    logic off_expire;
    logic dim_change;
    logic off_change;
    logic group_on;
    timeout_state_type state_q;
    timeout_state_type state_d;

    // Register writes; bit 7 is not stored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sink_assign_q <= SINK_ASSIGN_RESET;
            off_delay_q <= OFF_DELAY_RESET;
            dim_delay_q <= DIM_DELAY_RESET;
        end else if (reg_write) begin
            if (reg_addr == ADDR_SINK_ASSIGN) begin
                sink_assign_q <= reg_wdata[LED_COUNT-1:0];
            end
            if (reg_addr == ADDR_OFF_DELAY) begin
                off_delay_q <= reg_wdata[DELAY_W-1:0];
            end
            if (reg_addr == ADDR_DIM_DELAY) begin
                dim_delay_q <= reg_wdata[DELAY_W-1:0];
            end
        end
    end

    // Reserved bit 7 and unmapped addresses read back as zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata_q <= READ_ZERO;
        end else if (reg_read) begin
            unique case (reg_addr)
                ADDR_SINK_ASSIGN: reg_rdata_q <= {1'b0, sink_assign_q};
                ADDR_OFF_DELAY: reg_rdata_q <= {1'b0, off_delay_q};
                ADDR_DIM_DELAY: reg_rdata_q <= {1'b0, dim_delay_q};
                default: reg_rdata_q <= READ_ZERO;
            endcase
        end
    end

    // Turn-on edge re-arms both counters and the prescaler
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enable_prev_q <= 1'b0;
        end else begin
            enable_prev_q <= backlight_group_enable;
        end
    end
    assign arm = backlight_group_enable && !enable_prev_q;

    // One-second tick, its phase set by the turn-on edge
    always_ff @(posedge clk) begin
        if (sys_rst || arm || prescale_q == TICK_W'(TICK_CYCLES - 1)) begin
            prescale_q <= '0;
        end else begin
            prescale_q <= prescale_q + 1'b1;
        end
    end
    assign tick = (prescale_q == TICK_W'(TICK_CYCLES - 1));

    assign dim_enabled = (dim_delay_q != DELAY_DISABLED);
    assign off_enabled = (off_delay_q != DELAY_DISABLED);
    assign dim_expire = (state_q == ST_COUNT_DIM) && dim_done;
    assign off_expire = (state_q == ST_COUNT_OFF) && off_done;

    // A change counts only while its delay is still enabled
    assign dim_change = dim_expire && dim_enabled;
    assign off_change = off_expire && off_enabled;

    // Both counters share the tick; only one runs at a time
    seconds_counter dim_counter (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(arm || state_q == ST_IDLE),
        .run(state_q == ST_COUNT_DIM),
        .tick(tick),
        .limit(dim_delay_q),
        .done(dim_done)
    );

    seconds_counter off_counter (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(arm || state_q == ST_IDLE),
        .run(state_q == ST_COUNT_OFF),
        .tick(tick),
        .limit(off_delay_q),
        .done(off_done)
    );

    // Ramp, dim count, off count, then hold or timed off
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (backlight_group_enable) begin
                    state_d = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (at_max_current) begin
                    if (dim_enabled) begin
                        state_d = ST_COUNT_DIM;
                    end else if (off_enabled) begin
                        state_d = ST_COUNT_OFF;
                    end else begin
                        state_d = ST_HOLD;
                    end
                end
            end
            ST_COUNT_DIM: begin
                if (!dim_enabled) begin
                    state_d = ST_HOLD;
                end else if (dim_done) begin
                    state_d = off_enabled ? ST_COUNT_OFF : ST_HOLD;
                end
            end
            ST_COUNT_OFF: begin
                if (!off_enabled) begin
                    state_d = ST_HOLD;
                end else if (off_done) begin
                    state_d = ST_TIMED_OFF;
                end
            end
            ST_HOLD: state_d = ST_HOLD;
            ST_TIMED_OFF: state_d = ST_TIMED_OFF;
            default: state_d = ST_IDLE;
        endcase
        if (!backlight_group_enable) begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Dim target stays until the group is switched off or re-armed
    always_ff @(posedge clk) begin
        if (sys_rst || !backlight_group_enable || arm) begin
            target_dim_q <= 1'b0;
        end else if (dim_change) begin
            target_dim_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !backlight_group_enable || arm) begin
            group_off_q <= 1'b0;
        end else if (off_change) begin
            group_off_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            transition_rate_q <= FADE_INSTANT;
            transition_instant_q <= 1'b1;
            transition_pulse_q <= 1'b0;
        end else begin
            transition_pulse_q <= dim_change || off_change;
            if (dim_change || off_change) begin
                transition_rate_q <= fade_out_rate;
                transition_instant_q <= (fade_out_rate == FADE_INSTANT);
            end
        end
    end

    // Group LEDs follow the enable until the off timeout fires
    assign group_on = backlight_group_enable && !group_off_q && state_q != ST_TIMED_OFF;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sink_on_q <= '0;
        end else begin
            for (int i = 0; i < LED_COUNT; i++) begin
                sink_on_q[i] <= sink_assign_q[i] ? led_independent_on[i] : group_on;
            end
        end
    end
endmodule

// ---- logic/seconds_counter.sv ----
// Seconds counter that flags expiry after a programmed number of ticks
`timescale 1ns/1ps
module seconds_counter
    import backlight_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic clear, // Restart count from zero
    input wire logic run, // Count ticks while high
    input wire logic tick, // One-second tick pulse
    input wire logic [DELAY_W-1:0] limit, // Delay in seconds
    output logic done // Level, set once limit reached
);
    logic [DELAY_W-1:0] count_q;
    logic done_q;

    always_ff @(posedge clk) begin
        if (sys_rst || clear) begin
            count_q <= DELAY_DISABLED;
        end else if (run && tick && !done_q) begin
            count_q <= count_q + 7'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || clear) begin
            done_q <= 1'b0;
        end else if (run && tick && !done_q && (count_q + 7'h01) == limit) begin
            done_q <= 1'b1;
        end
    end

    assign done = done_q;
endmodule

// ---- testbench/backlight_assertions.sv ----
// Checker for register reads, sink selection and timeout outputs
`timescale 1ns/1ps
module backlight_assertions
    import backlight_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic [7:0] reg_addr, // Address
    input wire logic [7:0] reg_wdata, // Data
    input wire logic reg_write, // Write
    input wire logic reg_read, // Read
    input wire logic [7:0] reg_rdata_q, // Read data
    input wire logic backlight_group_enable, // Enable
    input wire logic [6:0] led_independent_on, // Own enables
    input wire logic [6:0] sink_on_q, // Sinks
    input wire logic target_dim_q, // Dim
    input wire logic group_off_q, // Off
    input wire logic [3:0] transition_rate_q, // Rate
    input wire logic transition_instant_q, // Instant
    input wire logic transition_pulse_q // Pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [6:0] shd_q [5:7];
    logic [6:0] sel;
    logic [6:0] dim;
    logic [7:0] exp_rd;
    wire logic hit = reg_addr >= 8'h05 && reg_addr <= 8'h07;
    // Shadow copy of the writable fields
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shd_q <= '{default: 7'h00};
        end else if (reg_write && hit) begin
            shd_q[reg_addr] <= reg_wdata[6:0];
        end
    end
    assign sel = shd_q[5];
    assign dim = shd_q[7];
    assign exp_rd = hit ? {1'b0, shd_q[reg_addr]} : 8'h00;
    sequence s_change;
        $rose(target_dim_q) || $rose(group_off_q);
    endsequence
    property p_read;
        reg_read |=> reg_rdata_q == $past(exp_rd);
    endproperty
    property p_indep;
        (sink_on_q & $past(sel)) == $past(led_independent_on & sel);
    endproperty
    property p_grp;
        !$past(backlight_group_enable) |-> (sink_on_q & ~$past(sel)) == 7'h00;
    endproperty
    property p_off;
        $rose(group_off_q) |=> (sink_on_q & ~sel) == 7'h00;
    endproperty
    property p_pulse;
        s_change |-> transition_pulse_q ##1 !transition_pulse_q;
    endproperty
    property p_inst;
        transition_pulse_q |-> transition_instant_q == (transition_rate_q == FADE_INSTANT);
    endproperty
    property p_dim;
        $rose(target_dim_q) |-> $past(dim, 2) != 7'h00;
    endproperty
    property p_idle;
        !backlight_group_enable [*3] |-> !target_dim_q && !group_off_q;
    endproperty
    a_read: assert property (p_read) else $error("read data wrong");
    a_indep: assert property (p_indep) else $error("own sink wrong");
    a_grp: assert property (p_grp) else $error("group sink on");
    a_off: assert property (p_off) else $error("sink on after off");
    a_pulse: assert property (p_pulse) else $error("pulse wrong");
    a_inst: assert property (p_inst) else $error("instant flag wrong");
    a_dim: assert property (p_dim) else $error("dim while disabled");
    a_idle: assert property (p_idle) else $error("timeout not idle");
endmodule
bind backlight_sink_and_timeouts backlight_assertions i_backlight_assertions (.*);

// ---- testbench/backlight_sink_and_timeouts_tb_top.sv ----
// Testbench for sink selection and cascaded timeouts
`timescale 1ns/1ps
module backlight_sink_and_timeouts_tb_top;
    import backlight_pkg::*;
    localparam int T = 4;
    logic clk, sys_rst, en, at_max, wr, rd, dim_q, off_q, pulse, inst;
    logic [7:0] addr, wdata, rdata, q;
    logic [3:0] rate, tr_rate;
    logic [6:0] ind, sink;
    int err_count = 0;
    int total_checks = 0;
    host_model i_host_model (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd));
    backlight_sink_and_timeouts #(.TICK_CYCLES(T)) i_backlight_sink_and_timeouts (.clk(clk),
        .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr),
        .reg_read(rd), .reg_rdata_q(rdata), .backlight_group_enable(en),
        .at_max_current(at_max), .fade_out_rate(rate), .led_independent_on(ind),
        .sink_on_q(sink), .target_dim_q(dim_q), .group_off_q(off_q),
        .transition_rate_q(tr_rate), .transition_instant_q(inst), .transition_pulse_q(pulse));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        i_host_model.xfer(1'b0, a, 8'h00, q);
        check(name, q, exp);
    endtask
    task automatic wait_for(input bit off, output int n);
        n = 0;
        while ((off ? off_q : dim_q) !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic t_regs();
        rd_chk("sink_rst", 8'h05, 8'h00);
        rd_chk("off_rst", 8'h06, 8'h00);
        rd_chk("dim_rst", 8'h07, 8'h00);
        for (int a = 5; a <= 8; a++) begin
            i_host_model.xfer(1'b1, 8'(a), 8'hff, q);
            rd_chk("rsv", 8'(a), a < 8 ? 8'h7f : 8'h00);
        end
        $display("t_regs done");
    endtask
    task automatic t_sinks();
        i_host_model.xfer(1'b1, 8'h05, 8'h55, q);
        ind = 7'h7f;
        repeat (2) @(negedge clk);
        check("sink_own", {1'b0, sink}, 8'h55);
        en = 1'b1;
        ind = 7'h00;
        repeat (2) @(negedge clk);
        check("sink_grp", {1'b0, sink}, 8'h2a);
        en = 1'b0;
        i_host_model.xfer(1'b1, 8'h05, 8'h00, q);
        $display("t_sinks done");
    endtask
    task automatic t_cascade(input logic [6:0] dim, input logic [6:0] off,
        input logic [3:0] fr);
        int n;
        i_host_model.xfer(1'b1, 8'h06, {1'b0, off}, q);
        i_host_model.xfer(1'b1, 8'h07, {1'b0, dim}, q);
        rate = fr;
        en = 1'b1;
        repeat (3 * T) @(negedge clk);
        check("early", {7'h00, dim_q}, 8'h00);
        at_max = 1'b1;
        if (dim != 7'h00) begin
            wait_for(1'b0, n);
            check("dim_t", 8'(n >= dim * T && n <= (dim + 1) * T + 2), 8'h01);
            check("dim_pulse", {7'h00, pulse}, 8'h01);
            check("rate", {4'h0, tr_rate}, {4'h0, fr});
        end
        if (off != 7'h00) begin
            wait_for(1'b1, n);
            check("off_t", 8'(n >= off * T && n <= (off + 1) * T + 2), 8'h01);
            check("off_pulse", {7'h00, pulse}, 8'h01);
            repeat (2) @(negedge clk);
            check("sink_off", {1'b0, sink}, 8'h00);
        end else begin
            repeat (4 * T) @(negedge clk);
            check("no_off", {7'h00, off_q}, 8'h00);
            check("sink_held", {1'b0, sink}, 8'h7f);
        end
        check("inst", {7'h00, inst}, 8'(fr == FADE_INSTANT));
        check("dim_state", {7'h00, dim_q}, {7'h00, dim != 7'h00});
        en = 1'b0;
        at_max = 1'b0;
        repeat (4) @(negedge clk);
        check("sink_idle", {1'b0, sink}, 8'h00);
        $display("t_cascade done");
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        sys_rst = 1'b1;
        en = 1'b0;
        at_max = 1'b0;
        rate = 4'h0;
        ind = 7'h00;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        t_regs();
        t_sinks();
        t_cascade(7'h02, 7'h02, 4'h3);
        t_cascade(7'h00, 7'h02, 4'h0);
        t_cascade(7'h01, 7'h00, 4'h5);
        final_report();
    end
    initial begin
        #20000;
        err_count++;
        final_report();
    end
endmodule

// ---- testbench/host_model.sv ----
// Host model that drives register strobes
`timescale 1ns/1ps
module host_model (
    input wire logic clk, // Clock
    input wire logic [7:0] rdata, // Read data
    output logic [7:0] addr, // Address
    output logic [7:0] wdata, // Write data
    output logic wr, // Write
    output logic rd // Read
);
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(negedge clk);
        q = rdata;
        wr = 1'b0;
        rd = 1'b0;
        // Idle bus shows no stale value
        addr = ~a;
        wdata = ~d;
    endtask
endmodule
